// file: verilog/io_ports_pkg.sv
// Purpose: shared constants for the two eight-bit general-purpose ports
// Assumes: Avalon-MM byte addressing, register byte address = 4 * index
// Notes: indices are the printed register offsets
package io_ports_pkg;
    // ==========================================================
    // widths
    localparam int PORT_W = 8;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int IDX_W = 16;

    // ==========================================================
    // register indices
    localparam logic [IDX_W-1:0] IDX_FIVE_DATA = 16'hffd8;
    localparam logic [IDX_W-1:0] IDX_FIVE_DIR = 16'hffe8;
    localparam logic [IDX_W-1:0] IDX_FIVE_PULLUP = 16'hffef;
    localparam logic [IDX_W-1:0] IDX_SIX_DATA = 16'hffd9;
    localparam logic [IDX_W-1:0] IDX_SIX_DIR = 16'hffe9;
    localparam int IDX_LSB = 2;

    // ==========================================================
    // port five pins that also feed peripherals
    localparam int TIMER_B_PIN = 6;
    localparam int ADC_TRIG_PIN = 5;

    // ==========================================================
    // reset and fixed read values
    localparam logic [PORT_W-1:0] PORT_RESET = 8'h00;
    localparam logic [PORT_W-1:0] DIR_READBACK = 8'hff;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    // ==========================================================
    // power modes
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b000,
        MODE_SLEEP = 3'b001,
        MODE_SUBSLEEP = 3'b010,
        MODE_STANDBY = 3'b011,
        MODE_WATCH = 3'b100,
        MODE_SUBACTIVE = 3'b101
    } power_mode_t;
endpackage

// file: verilog/io_pin_cell.sv
// Purpose: one port pin: output stage, pull-up and input synchroniser
// Assumes: mode qualifiers come from the parent on the same clock
// Notes: outputs are registered, so a drive change shows one clock later and pin_level two clocks later
`timescale 1ns/1ps
module io_pin_cell (
    input wire logic clock,
    input wire logic rst,
    input wire logic dir,
    input wire logic data,
    input wire logic pullup_ctl,
    input wire logic functional,
    input wire logic hold,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic pullup_on,
    output logic pin_level
);
    logic sync1_r;
    logic sync2_r;
    logic pull_nxt;

    // ==========================================================
    // output stage
    assign pull_nxt = ~dir & pullup_ctl;

    // reset floats the pin and drops the pull-up
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
            pullup_on <= 1'b0;
        end else if (hold) begin
            pin_o <= pin_o;
            pin_oe <= pin_oe;
            pullup_on <= pullup_on;
        end else if (functional) begin
            pin_o <= data;
            pin_oe <= dir;
            pullup_on <= pull_nxt;
        end else begin
            // standby and watch: float, pull-up still may hold the pin high
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
            pullup_on <= pull_nxt;
        end
    end

    // ==========================================================
    // input synchroniser
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
        end
    end

    assign pin_level = sync2_r;
endmodule // io_pin_cell

// file: verilog/io_ports.sv
// Purpose: two eight-bit general-purpose ports behind an Avalon-MM slave
// Assumes: 20 MHz clock, pins asynchronous to it
// Notes: every access takes two cycles (one wait state)
//
// How it works
// - port five direction bit picks input or output
// - port five pins feed interrupt, timer, converter
// - pins float, hold or run per power mode
// - pull-up on only for input with bit set
// - pull-ups off after reset
// - port six read: data if output, pin if input
// - port six data: eight bits, RW, resets zero
// - port six direction one means output
// - port six direction write-only, reads ones, resets zero
// - port six registers at their printed indices
// - port five read: data if output, pin if input
// - port five direction write-only, reads all ones
// - port six pins follow the same mode states
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module io_ports (
    input wire logic clock,
    input wire logic rst,
    input wire logic [io_ports_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [io_ports_pkg::DATA_W-1:0] writedata,
    output logic [io_ports_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic [2:0] power_mode,
    input wire logic [io_ports_pkg::PORT_W-1:0] five_pin_i,
    output logic [io_ports_pkg::PORT_W-1:0] five_pin_o,
    output logic [io_ports_pkg::PORT_W-1:0] five_pin_oe,
    output logic [io_ports_pkg::PORT_W-1:0] five_pullup_on,
    input wire logic [io_ports_pkg::PORT_W-1:0] six_pin_i,
    output logic [io_ports_pkg::PORT_W-1:0] six_pin_o,
    output logic [io_ports_pkg::PORT_W-1:0] six_pin_oe,
    output logic [io_ports_pkg::PORT_W-1:0] ext_irq_in,
    output logic timer_b_event_input,
    output logic adc_external_trigger
);
    localparam int W = io_ports_pkg::PORT_W;

    logic [W-1:0] port_five_data_r;
    logic [W-1:0] port_five_direction_r;
    logic [W-1:0] port_five_pullup_enable_r;
    logic [W-1:0] port_six_data_r;
    logic [W-1:0] port_six_direction_r;
    logic [W-1:0] five_level;
    logic [W-1:0] six_level;
    logic [W-1:0] six_pullup_unused;
    logic [io_ports_pkg::IDX_W-1:0] idx;
    logic ack_r;
    logic sel_five_data;
    logic sel_five_dir;
    logic sel_five_pullup;
    logic sel_six_data;
    logic sel_six_dir;
    logic wr_go;
    logic rd_capture;
    logic [W-1:0] five_view;
    logic [W-1:0] six_view;
    logic functional;
    logic hold;
    logic [io_ports_pkg::DATA_W-1:0] read_nxt;
    logic [io_ports_pkg::DATA_W-1:0] readdata_r;

    // ==========================================================
    // bus handshake
    // first cycle raises waitrequest, second completes the access
    assign waitrequest = (read | write) & ~ack_r;
    assign wr_go = write & ack_r;
    assign idx = address[io_ports_pkg::IDX_LSB +: io_ports_pkg::IDX_W];
    assign readdata = readdata_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (read | write) & ~ack_r;
        end
    end

    // ==========================================================
    // register decode
    // full index match, so no alias of a register answers
    assign sel_five_data = (idx == io_ports_pkg::IDX_FIVE_DATA);
    assign sel_five_dir = (idx == io_ports_pkg::IDX_FIVE_DIR);
    assign sel_five_pullup = (idx == io_ports_pkg::IDX_FIVE_PULLUP);
    assign sel_six_data = (idx == io_ports_pkg::IDX_SIX_DATA);
    assign sel_six_dir = (idx == io_ports_pkg::IDX_SIX_DIR);
    assign rd_capture = read & ~ack_r;

    // ==========================================================
    // register writes
    // unmapped writes match no select and are dropped
    always_ff @(posedge clock) begin
        if (rst) begin
            port_five_data_r <= io_ports_pkg::PORT_RESET;
        end else if (wr_go & sel_five_data) begin
            port_five_data_r <= writedata[W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_five_direction_r <= io_ports_pkg::PORT_RESET;
        end else if (wr_go & sel_five_dir) begin
            port_five_direction_r <= writedata[W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_five_pullup_enable_r <= io_ports_pkg::PORT_RESET;
        end else if (wr_go & sel_five_pullup) begin
            port_five_pullup_enable_r <= writedata[W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_six_data_r <= io_ports_pkg::PORT_RESET;
        end else if (wr_go & sel_six_data) begin
            port_six_data_r <= writedata[W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_six_direction_r <= io_ports_pkg::PORT_RESET;
        end else if (wr_go & sel_six_dir) begin
            port_six_direction_r <= writedata[W-1:0];
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        read_nxt = io_ports_pkg::UNMAPPED_READ;
        case (idx)
            io_ports_pkg::IDX_FIVE_DATA: begin
                read_nxt[W-1:0] = five_view;
            end
            io_ports_pkg::IDX_FIVE_DIR: begin
                read_nxt[W-1:0] = io_ports_pkg::DIR_READBACK;
            end
            io_ports_pkg::IDX_FIVE_PULLUP: begin
                read_nxt[W-1:0] = port_five_pullup_enable_r;
            end
            io_ports_pkg::IDX_SIX_DATA: begin
                read_nxt[W-1:0] = six_view;
            end
            io_ports_pkg::IDX_SIX_DIR: begin
                read_nxt[W-1:0] = io_ports_pkg::DIR_READBACK;
            end
            default: begin
                read_nxt = io_ports_pkg::UNMAPPED_READ;
            end
        endcase
    end

    // captured in the wait cycle so it stands at the completing edge
    always_ff @(posedge clock) begin
        if (rst) begin
            readdata_r <= io_ports_pkg::UNMAPPED_READ;
        end else if (rd_capture) begin
            readdata_r <= read_nxt;
        end
    end

    // ==========================================================
    // power mode decode
    always_comb begin
        functional = 1'b0;
        hold = 1'b0;
        case (power_mode)
            io_ports_pkg::MODE_ACTIVE, io_ports_pkg::MODE_SUBACTIVE: begin
                functional = 1'b1;
            end
            io_ports_pkg::MODE_SLEEP, io_ports_pkg::MODE_SUBSLEEP: begin
                hold = 1'b1;
            end
            default: begin
                // standby and watch float the pins
                functional = 1'b0;
                hold = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // pin cells
    for (genvar n = 0; n < W; n++) begin : g_pin
        // output pins read the latch, so a loaded pin cannot corrupt the value
        assign five_view[n] = port_five_direction_r[n] ? port_five_data_r[n]
            : five_level[n];
        assign six_view[n] = port_six_direction_r[n] ? port_six_data_r[n]
            : six_level[n];
        io_pin_cell u_five (
            .clock(clock),
            .rst(rst),
            .dir(port_five_direction_r[n]),
            .data(port_five_data_r[n]),
            .pullup_ctl(port_five_pullup_enable_r[n]),
            .functional(functional),
            .hold(hold),
            .pin_i(five_pin_i[n]),
            .pin_o(five_pin_o[n]),
            .pin_oe(five_pin_oe[n]),
            .pullup_on(five_pullup_on[n]),
            .pin_level(five_level[n])
        );
        io_pin_cell u_six (
            .clock(clock),
            .rst(rst),
            .dir(port_six_direction_r[n]),
            .data(port_six_data_r[n]),
            .pullup_ctl(1'b0),
            .functional(functional),
            .hold(hold),
            .pin_i(six_pin_i[n]),
            .pin_o(six_pin_o[n]),
            .pin_oe(six_pin_oe[n]),
            .pullup_on(six_pullup_unused[n]),
            .pin_level(six_level[n])
        );
    end

    // ==========================================================
    // peripheral feeds, independent of direction
    assign ext_irq_in = five_level;
    assign timer_b_event_input = five_level[io_ports_pkg::TIMER_B_PIN];
    assign adc_external_trigger = five_level[io_ports_pkg::ADC_TRIG_PIN];
endmodule // io_ports

// file: verif/board_pins.sv
// Purpose: board side of one eight-bit port
// Assumes: bench chooses which pins it drives
// Notes: an undriven, unpulled pin toggles so a stale level cannot pass
`timescale 1ns/1ps
module board_pins (
    input logic clock,
    input logic [7:0] pin_o,
    input logic [7:0] pin_oe,
    input logic [7:0] pull_on,
    input logic [7:0] drv_en,
    input logic [7:0] drv,
    output logic [7:0] level
);
    // ==========================================
    // wire level
    logic [7:0] toggle_r = 8'h55;
    always @(posedge clock) begin
        toggle_r <= ~toggle_r;
    end
    assign level = (pin_oe & pin_o) | (~pin_oe & drv_en & drv)
        | (~pin_oe & ~drv_en & (pull_on | toggle_r));
endmodule // board_pins

// file: verif/io_ports_chk.sv
// Purpose: port-level checks of the two ports
// Assumes: one clock, synchronous reset
// Notes: bound to every io_ports instance
`timescale 1ns/1ps
module io_ports_chk (
    input logic clock,
    input logic rst,
    input logic [17:0] address,
    input logic read,
    input logic write,
    input logic [31:0] writedata,
    input logic [31:0] readdata,
    input logic waitrequest,
    input logic [2:0] power_mode,
    input logic [7:0] five_pin_i,
    input logic [7:0] five_pin_oe,
    input logic [7:0] five_pullup_on,
    input logic [7:0] six_pin_o,
    input logic [7:0] six_pin_oe,
    input logic [7:0] ext_irq_in,
    input logic timer_b_event_input,
    input logic adc_external_trigger
);
    // ==========================================
    // checks
    logic [15:0] idx;
    logic done_rd;
    logic mapped;
    assign idx = address[17:2];
    assign done_rd = read && !waitrequest;
    assign mapped = idx inside {16'hffd8, 16'hffd9, 16'hffe8, 16'hffe9, 16'hffef};
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_out;
        logic [7:0] v;
        (write && !waitrequest && idx == io_ports_pkg::IDX_SIX_DATA && power_mode == 3'h0,
            v = writedata[7:0]) |-> ##2 ((six_pin_o ^ v) & six_pin_oe) == 8'h00;
    endproperty
    AST_WAIT: assert property ($rose(read | write) |-> waitrequest ##1 !waitrequest)
        else $error("access without one wait state");
    AST_OUT_FOLLOWS: assert property (p_out)
        else $error("output pins miss written data");
    AST_NO_PULL_OUT: assert property ((five_pullup_on & five_pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_RST_OFF: assert property (disable iff (1'b0) rst |=> five_pin_oe == 8'h00
        && six_pin_oe == 8'h00 && five_pullup_on == 8'h00) else $error("pins not off in reset");
    AST_IRQ_SYNC: assert property (!$past(rst) && !$past(rst, 2)
        |-> ext_irq_in == $past(five_pin_i, 2)) else $error("irq feed not pin level");
    AST_TAPS: assert property (timer_b_event_input == ext_irq_in[6]
        && adc_external_trigger == ext_irq_in[5]) else $error("timer or trigger feed wrong");
    AST_SLEEP_HOLD: assert property (!$past(rst) && $past(power_mode) inside {3'h1, 3'h2}
        |-> $stable(six_pin_oe) && $stable(six_pin_o) && $stable(five_pin_oe))
        else $error("pins moved while held");
    AST_FLOAT: assert property (!$past(rst) && $past(power_mode) inside {3'h3, 3'h4}
        |-> five_pin_oe == 8'h00 && six_pin_oe == 8'h00) else $error("pins driven while off");
    AST_DIR_ONES: assert property (done_rd && idx inside {16'hffe8, 16'hffe9}
        |-> readdata == 32'h0000_00ff) else $error("direction read not all ones");
    AST_UNMAPPED: assert property (done_rd && !mapped |-> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    cover property (done_rd);
    cover property (write && !waitrequest);
    cover property (power_mode == 3'h3);
endmodule // io_ports_chk
bind io_ports io_ports_chk chk_i (.clock, .rst, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .power_mode, .five_pin_i, .five_pin_oe, .five_pullup_on,
    .six_pin_o, .six_pin_oe, .ext_irq_in, .timer_b_event_input, .adc_external_trigger);

// file: verif/io_ports_tb.sv
// Purpose: register and pin tests of the two ports
// Assumes: one wait state per access, pins synced in two clocks
// Notes: bus answers taken at the rising edge, pins compared at the falling edge
`timescale 1ns/1ps
module io_ports_tb;
    // ==========================================
    // bench
    logic clock, rst, read, write, waitrequest, timer_b_event_input, adc_external_trigger;
    logic [17:0] address;
    logic [31:0] writedata, readdata;
    logic [2:0] power_mode;
    logic [7:0] five_pin_i, five_pin_o, five_pin_oe, five_pullup_on, ext_irq_in, v;
    logic [7:0] six_pin_i, six_pin_o, six_pin_oe, five_en, five_drv, six_en, six_drv;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    io_ports dut (.clock, .rst, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .power_mode, .five_pin_i, .five_pin_o, .five_pin_oe, .five_pullup_on,
        .six_pin_i, .six_pin_o, .six_pin_oe, .ext_irq_in, .timer_b_event_input,
        .adc_external_trigger);
    board_pins five_b (.clock, .pin_o(five_pin_o), .pin_oe(five_pin_oe),
        .pull_on(five_pullup_on), .drv_en(five_en), .drv(five_drv), .level(five_pin_i));
    board_pins six_b (.clock, .pin_o(six_pin_o), .pin_oe(six_pin_oe), .pull_on(8'h00),
        .drv_en(six_en), .drv(six_drv), .level(six_pin_i));
    task automatic wrap_up();
        $display("mismatches %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] d);
        @(posedge clock);
        address <= {i, 2'b00};
        writedata <= {24'h000000, d};
        write <= w;
        read <= !w;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        v = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [15:0] i, input logic [7:0] e);
        acc(1'b0, i, 8'h00);
        chk(n, e, v);
    endtask
    task automatic pins(input int n, input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] c);
        repeat (n) @(posedge clock);
        @(negedge clock);
        chk("six_oe", a, six_pin_oe);
        chk("five_oe", b, five_pin_oe);
        chk("pull_on", c, five_pullup_on);
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        {rst, read, write, address, writedata, power_mode} = {1'b1, 55'h0};
        {five_en, five_drv, six_en, six_drv} = 32'hffc3_ff5a;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd("six_data", io_ports_pkg::IDX_SIX_DATA, 8'h00);
        rd("six_dir", io_ports_pkg::IDX_SIX_DIR, 8'hff);
        rd("five_dir", io_ports_pkg::IDX_FIVE_DIR, 8'hff);
        rd("five_pull", io_ports_pkg::IDX_FIVE_PULLUP, 8'h00);
        pins(0, 8'h00, 8'h00, 8'h00);
        acc(1'b1, io_ports_pkg::IDX_SIX_DIR, 8'h0f);
        acc(1'b1, io_ports_pkg::IDX_SIX_DATA, 8'ha5);
        rd("six_mix", io_ports_pkg::IDX_SIX_DATA, 8'h55);
        pins(0, 8'h0f, 8'h00, 8'h00);
        chk("six_out", 8'h05, six_pin_o & 8'h0f);
        acc(1'b1, io_ports_pkg::IDX_SIX_DIR, 8'hff);
        acc(1'b1, io_ports_pkg::IDX_SIX_DATA, 8'h3c);
        rd("six_rw", io_ports_pkg::IDX_SIX_DATA, 8'h3c);
        acc(1'b1, io_ports_pkg::IDX_FIVE_DIR, 8'hf0);
        acc(1'b1, io_ports_pkg::IDX_FIVE_PULLUP, 8'hff);
        acc(1'b1, io_ports_pkg::IDX_FIVE_DATA, 8'h6c);
        rd("five_mix", io_ports_pkg::IDX_FIVE_DATA, 8'h63);
        pins(1, 8'hff, 8'hf0, 8'h0f);
        chk("five_out", 8'h60, five_pin_o & 8'hf0);
        chk("irq", 8'h63, ext_irq_in);
        chk("taps", 8'h03, {6'h00, timer_b_event_input, adc_external_trigger});
        @(posedge clock);
        five_en <= 8'h00;
        repeat (3) @(posedge clock);
        rd("five_pulled", io_ports_pkg::IDX_FIVE_DATA, 8'h6f);
        // sleep modes hold, standby, watch and spare codes float, subactive runs
        for (int m = 1; m < 8; m++) begin
            @(posedge clock);
            power_mode <= 3'(m);
            acc(1'b1, io_ports_pkg::IDX_SIX_DIR, 8'h00);
            pins(2, m < 3 ? 8'hff : 8'h00,
                (m < 3 || m == 5) ? 8'hf0 : 8'h00, 8'h0f);
            @(posedge clock);
            power_mode <= (m < 3) ? 3'h0 : 3'h5;
            pins(2, 8'h00, 8'hf0, 8'h0f);
            acc(1'b1, io_ports_pkg::IDX_SIX_DIR, 8'hff);
        end
        acc(1'b1, 16'hffd0, 8'h77);
        rd("unmapped", 16'hffd0, 8'h00);
        rd("six_keep", io_ports_pkg::IDX_SIX_DATA, 8'h3c);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd("six_rst", io_ports_pkg::IDX_SIX_DATA, 8'h00);
        rd("pull_rst", io_ports_pkg::IDX_FIVE_PULLUP, 8'h00);
        pins(0, 8'h00, 8'h00, 8'h00);
        wrap_up();
    end
endmodule // io_ports_tb
